// ---- logic/ccm_endpoint.sv ----
// Endpoint end: publishes configuration fields, reserved completion
// space, and returns the completion credits of the last issued request.
// Assumes the manager never oversubscribes the reserved space.
`timescale 1ns/1ps
`default_nettype none
module ccm_endpoint (
  ccm_link_if.endpoint      lnk,
  input  wire logic [2:0]   cfg_mrs_code,
  input  wire logic         cfg_rcb_128,
  input  wire logic [1:0]   cfg_mps,
  input  wire logic         cfg_high_perf,
  input  wire logic         cfg_keep_digest,
  input  wire logic         cpl_return,
  input  wire logic         cpl_last,
  output logic              overflow
);
  typedef struct packed {
    logic [15:0] dctl;
    logic [15:0] lctl;
    logic [9:0]  dcap;
    logic [9:0]  hold_h;
    logic [9:0]  hold_d;
    logic        cv;
    logic        cdone;
    logic        dig;
    logic [9:0]  ret_h;
    logic [9:0]  ret_d;
    logic        ovf;
  } ccm_ep_s;

  ccm_ep_s st_q, st_d;
  logic [9:0] dcap_c;

  always_comb begin
    unique case (cfg_mps)
      2'h0, 2'h1: dcap_c = cfg_high_perf ? ccm_pkg::DATA_CAP_HIGH_S
                                          : ccm_pkg::DATA_CAP_GOOD_S;
      ccm_pkg::MPS_512: dcap_c = cfg_high_perf ? ccm_pkg::DATA_CAP_HIGH_M
                                               : ccm_pkg::DATA_CAP_GOOD_M;
      ccm_pkg::MPS_1024: dcap_c = cfg_high_perf ? ccm_pkg::DATA_CAP_HIGH_L
                                                : ccm_pkg::DATA_CAP_GOOD_L;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.dctl = '0;
    st_d.dctl[ccm_pkg::MRS_HI:ccm_pkg::MRS_LO] = cfg_mrs_code;
    st_d.lctl = '0;
    st_d.lctl[ccm_pkg::RCB_BIT] = cfg_rcb_128;
    st_d.dcap = dcap_c;
    st_d.dig = cfg_keep_digest;
    st_d.cv = 1'b0;
    st_d.cdone = 1'b0;
    st_d.ret_h = 10'h000;
    st_d.ret_d = 10'h000;
    // Remember credits of the last request; return them all in the
    // last completion event, and none in the completions before it.
    if (lnk.req_valid) begin
      st_d.hold_h = lnk.req_hdr;
      st_d.hold_d = lnk.req_data;
      if (lnk.req_hdr > ccm_pkg::HDR_CAP || lnk.req_data > dcap_c) begin
        st_d.ovf = 1'b1;
      end
    end else if (cpl_return && lnk.rx_ready && st_q.hold_h != 10'h000) begin
      st_d.cv = 1'b1;
      st_d.cdone = cpl_last;
      // Returned amounts are latched apart, since the hold clears now
      st_d.ret_h = cpl_last ? st_q.hold_h : 10'h000;
      st_d.ret_d = cpl_last ? st_q.hold_d : 10'h000;
      st_d.hold_h = cpl_last ? 10'h000 : st_q.hold_h;
      st_d.hold_d = cpl_last ? 10'h000 : st_q.hold_d;
    end
  end

  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk.dev_control   = st_q.dctl;
  assign lnk.link_control  = st_q.lctl;
  assign lnk.hdr_capacity  = ccm_pkg::HDR_CAP;
  assign lnk.data_capacity = st_q.dcap;
  assign lnk.cpl_unlimited = 1'b1;
  assign lnk.digest_kept   = st_q.dig;
  assign lnk.cpl_valid     = st_q.cv;
  assign lnk.cpl_hdr       = st_q.ret_h;
  assign lnk.cpl_data      = st_q.ret_d;
  assign lnk.cpl_done      = st_q.cdone;
  assign overflow          = st_q.ovf;
endmodule
`default_nettype wire

// ---- logic/ccm_manager.sv ----
// Request manager: APB programmed, computes completion credit needs
// of each non-posted request and gates issue by method: free space, request count, or not at all at line rate.
// Assumes the endpoint link and APB share clk.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ccm_manager (
  ccm_link_if.manager       lnk,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [12:0] len;
    logic [9:0]  pend_h;
    logic [9:0]  pend_d;
    logic [7:0]  np_cnt;
    logic        req_v;
    logic [9:0]  req_h;
    logic [9:0]  req_d;
    logic        blocked;
    logic        too_long;
    logic        issued;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } ccm_mg_s;

  ccm_mg_s st_q, st_d;

  logic [2:0]  method;
  logic [12:0] rcb_b;
  logic [9:0]  rcb_c;
  logic [12:0] mrs_b;
  logic [9:0]  mrs_c;
  logic [13:0] span_h;
  logic [13:0] span_d;
  logic [9:0]  need_h;
  logic [9:0]  need_d;
  logic [9:0]  np_max;
  logic [9:0]  pkt_h;
  logic [9:0]  pkt_d;
  logic [9:0]  fh;
  logic [9:0]  fd;
  logic [12:0] eff_len;
  logic        fits;
  logic        access;

  // ===========================================================
  // Credit need of the request held in the address/length registers
  always_comb begin
    method = st_q.ctrl[ccm_pkg::CTRL_METHOD_LO +: 3];
    if (st_q.ctrl[ccm_pkg::CTRL_USE_CFG]) begin
      rcb_b = lnk.link_control[ccm_pkg::RCB_BIT] ? 13'(ccm_pkg::RCB_BYTES_1)
                                                 : 13'(ccm_pkg::RCB_BYTES_0);
      rcb_c = lnk.link_control[ccm_pkg::RCB_BIT] ? 10'(ccm_pkg::RCB_CRED_1)
                                                 : 10'(ccm_pkg::RCB_CRED_0);
      if (lnk.dev_control[ccm_pkg::MRS_HI:ccm_pkg::MRS_LO]
          > ccm_pkg::MRS_MAX_CODE) begin
        mrs_b = ccm_pkg::MRS_BASE_BYTES; // Reserved codes fall back
        mrs_c = 10'(ccm_pkg::MRS_BASE_CRED);
      end else begin
        mrs_b = ccm_pkg::MRS_BASE_BYTES
                << lnk.dev_control[ccm_pkg::MRS_HI:ccm_pkg::MRS_LO];
        mrs_c = 10'(ccm_pkg::MRS_BASE_CRED)
                << lnk.dev_control[ccm_pkg::MRS_HI:ccm_pkg::MRS_LO];
      end
    end else begin
      rcb_b = 13'(ccm_pkg::RCB_BYTES_0);
      rcb_c = 10'(ccm_pkg::RCB_CRED_0);
      mrs_b = ccm_pkg::MRS_BASE_BYTES;
      mrs_c = 10'(ccm_pkg::MRS_BASE_CRED);
    end
    eff_len = st_q.len + (lnk.digest_kept ? 13'(ccm_pkg::DIGEST_BYTES)
                                          : 13'h0000);
    // Boundary blocks spanned; aligned inner completions assumed
    span_h = 14'((st_q.addr[12:0] & (rcb_b - 13'h0001))) + 14'(eff_len)
             + 14'(rcb_b) - 14'h0001;
    need_h = 10'(span_h >> (rcb_b == 13'(ccm_pkg::RCB_BYTES_1) ? 7 : 6));
    span_d = 14'(st_q.addr[3:0]) + 14'(eff_len) + 14'h000f;
    need_d = st_q.ctrl[ccm_pkg::CTRL_NODATA] ? 10'h000 : 10'(span_d >> 4);
    // Per boundary method reserves data in whole boundary blocks
    if (method == ccm_pkg::CCM_PER_BOUND) begin
      need_d = st_q.ctrl[ccm_pkg::CTRL_NODATA] ? 10'h000 : 10'(need_h * rcb_c);
    end
    pkt_h = 10'(({3'h0, mrs_b} + {3'h0, rcb_b} - 16'h0001) / {3'h0, rcb_b});
    pkt_d = mrs_c;
    np_max = 10'(lnk.hdr_capacity / pkt_h);
    if (10'(lnk.data_capacity / pkt_d) < np_max) begin
      np_max = 10'(lnk.data_capacity / pkt_d);
    end
    fh = 10'(st_q.pend_h + need_h);
    fd = 10'(st_q.pend_d + need_d);
    unique case (method)
      ccm_pkg::CCM_REQ_COUNT:
        fits = {2'h0, st_q.np_cnt} < np_max;
      ccm_pkg::CCM_LINE_RATE:
        fits = 1'b1;
      default:
        fits = fh <= lnk.hdr_capacity && fd <= lnk.data_capacity;
    endcase
  end

  // ===========================================================
  // APB slave and issue logic
  always_comb begin
    st_d = st_q;
    access = psel && penable && !st_q.rdy;
    st_d.rdy = access;
    st_d.err = 1'b0;
    st_d.req_v = 1'b0;
    if (access) begin
      unique case (paddr)
        ccm_pkg::REG_CTRL: st_d.rdata = st_q.ctrl;
        ccm_pkg::REG_REQ_ADDR: st_d.rdata = st_q.addr;
        ccm_pkg::REG_REQ_LEN: st_d.rdata = {19'h0, st_q.len};
        ccm_pkg::REG_STATUS: st_d.rdata = {27'h0, lnk.cpl_unlimited,
          st_q.too_long, st_q.blocked, fits, st_q.issued};
        ccm_pkg::REG_PENDING: st_d.rdata = {4'h0, st_q.np_cnt,
          st_q.pend_d, st_q.pend_h};
        ccm_pkg::REG_CAPACITY: st_d.rdata = {12'h0, lnk.data_capacity,
          lnk.hdr_capacity};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.err = 1'b1;
        end
      endcase
      if (pwrite) begin
        unique case (paddr)
          ccm_pkg::REG_CTRL: st_d.ctrl = {23'h0, 1'b0, pwdata[7:0]};
          ccm_pkg::REG_REQ_ADDR: st_d.addr = pwdata;
          ccm_pkg::REG_REQ_LEN: st_d.len = pwdata[12:0];
          default: st_d.err = 1'b1;
        endcase
        if (paddr == ccm_pkg::REG_CTRL && pwdata[ccm_pkg::CTRL_GO]) begin
          // Status flags tell the outcome of the last GO until the next
          st_d.issued = 1'b0;
          st_d.blocked = 1'b0;
          st_d.too_long = 1'b0;
          if (st_q.len > mrs_b) begin
            st_d.too_long = 1'b1;
          end else if (fits) begin
            st_d.req_v = 1'b1;
            st_d.req_h = need_h;
            st_d.req_d = need_d;
            st_d.issued = 1'b1;
          end else begin
            st_d.blocked = 1'b1;
          end
        end
      end
    end
    // Allocation and release in one cycle both apply
    if (st_d.req_v && method != ccm_pkg::CCM_LINE_RATE) begin
      st_d.pend_h = 10'(st_d.pend_h + need_h);
      st_d.pend_d = 10'(st_d.pend_d + need_d);
      st_d.np_cnt = 8'(st_d.np_cnt + 8'h01);
    end
    // Line rate allocates nothing; a method change with requests out
    // leaves the counters stale, so change it only when idle
    if (lnk.cpl_valid && lnk.cpl_done
        && method != ccm_pkg::CCM_LINE_RATE) begin
      st_d.pend_h = 10'(st_d.pend_h - lnk.cpl_hdr);
      st_d.pend_d = 10'(st_d.pend_d - lnk.cpl_data);
      if (st_d.np_cnt != 8'h00) begin
        st_d.np_cnt = 8'(st_d.np_cnt - 8'h01);
      end
    end
  end

  always_ff @(posedge lnk.clk or negedge lnk.nrst) begin
    if (!lnk.nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk.req_valid = st_q.req_v;
  assign lnk.req_hdr   = st_q.req_h;
  assign lnk.req_data  = st_q.req_d;
  assign lnk.rx_ready  = 1'b1;
  assign prdata        = st_q.rdata;
  assign pready        = st_q.rdy;
  assign pslverr       = st_q.err;
endmodule
`default_nettype wire

// ---- pkg/ccm_link_if.sv ----
// Link between the endpoint credit side and the request manager.
// Assumes both ends run on the core user clock.
`timescale 1ns/1ps
`default_nettype none
interface ccm_link_if (
  input wire logic clk,
  input wire logic nrst
);
  logic [15:0] dev_control;     // Max request size in [14:12]
  logic [15:0] link_control;    // Completion boundary in [3]
  logic [9:0]  hdr_capacity;
  logic [9:0]  data_capacity;
  logic        cpl_unlimited;   // Infinite completion credits advertised
  logic        digest_kept;     // Incoming digests not stripped
  logic        req_valid;       // Non-posted request sent
  logic [9:0]  req_hdr;
  logic [9:0]  req_data;
  logic        cpl_valid;       // Completion seen; credits returned only with cpl_done
  logic [9:0]  cpl_hdr;
  logic [9:0]  cpl_data;
  logic        cpl_done;        // Request completely satisfied
  logic        rx_ready;        // Receive side not stalled

  modport endpoint (
    input  clk, nrst, req_valid, req_hdr, req_data, rx_ready,
    output dev_control, link_control, hdr_capacity, data_capacity,
    output cpl_unlimited, digest_kept, cpl_valid, cpl_hdr, cpl_data,
    output cpl_done
  );
  modport manager (
    input  clk, nrst, dev_control, link_control, hdr_capacity,
    input  data_capacity, cpl_unlimited, digest_kept, cpl_valid,
    input  cpl_hdr, cpl_data, cpl_done,
    output req_valid, req_hdr, req_data, rx_ready
  );
endinterface
`default_nettype wire

// ---- pkg/ccm_pkg.sv ----
// Constants shared by the completion credit manager ends.
// Assumes one user clock for both ends and a 32-bit APB on the manager.
package ccm_pkg;
  // ===========================================================
  // Reserved completion space
  localparam logic [9:0] HDR_CAP          = 10'd36;
  localparam logic [9:0] DATA_CAP_GOOD_S  = 10'd77;
  localparam logic [9:0] DATA_CAP_GOOD_M  = 10'd154;
  localparam logic [9:0] DATA_CAP_GOOD_L  = 10'd308;
  localparam logic [9:0] DATA_CAP_HIGH_S  = 10'd154;
  localparam logic [9:0] DATA_CAP_HIGH_M  = 10'd308;
  localparam logic [9:0] DATA_CAP_HIGH_L  = 10'd616;
  // Capability payload codes: 0=128 1=256 2=512 3=1024
  localparam logic [1:0] MPS_512          = 2'h2;
  localparam logic [1:0] MPS_1024         = 2'h3;
  // ===========================================================
  // Configuration field positions
  localparam int         MRS_HI           = 14;
  localparam int         MRS_LO           = 12;
  localparam int         RCB_BIT          = 3;
  localparam logic [2:0] MRS_MAX_CODE     = 3'h5;
  localparam logic [8:0] MRS_BASE_CRED    = 9'h008;
  localparam logic [12:0] MRS_BASE_BYTES  = 13'h0080;
  localparam logic [7:0] RCB_BYTES_0      = 8'h40;
  localparam logic [7:0] RCB_BYTES_1      = 8'h80;
  localparam logic [3:0] RCB_CRED_0       = 4'h4;
  localparam logic [3:0] RCB_CRED_1       = 4'h8;
  localparam logic [4:0] CRED_BYTES       = 5'h10;
  localparam logic [2:0] DIGEST_BYTES     = 3'h4;
  // ===========================================================
  // APB register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_REQ_ADDR     = 8'h04;
  localparam logic [7:0] REG_REQ_LEN      = 8'h08;
  localparam logic [7:0] REG_STATUS       = 8'h0c;
  localparam logic [7:0] REG_PENDING      = 8'h10;
  localparam logic [7:0] REG_CAPACITY     = 8'h14;
  // CTRL fields
  localparam int         CTRL_METHOD_LO   = 0;
  localparam int         CTRL_USE_CFG     = 4;
  localparam int         CTRL_NODATA      = 5;
  localparam int         CTRL_GO          = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // Count-method cap at 128 B request, 64 B boundary, good level
  localparam logic [7:0] NP_LIMIT_DEF     = 8'h09;

  typedef enum logic [2:0] {
    CCM_REQ_COUNT   = 3'b000,
    CCM_PER_PACKET  = 3'b001,
    CCM_PER_BOUND   = 3'b010,
    CCM_PER_DATA    = 3'b011,
    CCM_LINE_RATE   = 3'b100
  } ccm_method_e;
endpackage

// ---- tb/ccm_link_monitor.sv ----
// Checker on the link that joins the two credit manager ends.
// Assumes one clock domain; the bench wires it to the link signals.
`timescale 1ns/1ps
`default_nettype none
module ccm_link_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [9:0] hdr_capacity,
  input wire logic [9:0] data_capacity,
  input wire logic       cpl_unlimited,
  input wire logic       req_valid,
  input wire logic [9:0] req_hdr,
  input wire logic [9:0] req_data,
  input wire logic       cpl_valid,
  input wire logic [9:0] cpl_hdr,
  input wire logic [9:0] cpl_data,
  input wire logic       cpl_done,
  input wire logic       rx_ready
);
  // ==========================================================
  // Shadow of credits held, rebuilt from the link traffic alone
  logic [10:0] hp_q;
  logic [10:0] dp_q;
  logic        rel;
  assign rel = cpl_valid & cpl_done;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hp_q <= 11'h000;
      dp_q <= 11'h000;
    end else begin
      hp_q <= hp_q + (req_valid ? {1'b0, req_hdr} : 11'h000)
            - (rel ? {1'b0, cpl_hdr} : 11'h000);
      dp_q <= dp_q + (req_valid ? {1'b0, req_data} : 11'h000)
            - (rel ? {1'b0, cpl_data} : 11'h000);
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_hdr_cap_fixed: assert property ($past(nrst) |->
    hdr_capacity == ccm_pkg::HDR_CAP) else $error("header capacity");
  a_cpl_unlimited: assert property ($past(nrst) |-> cpl_unlimited)
    else $error("completion credits not unlimited");
  a_data_cap_legal: assert property ($past(nrst) |-> data_capacity
    inside {10'd77, 10'd154, 10'd308, 10'd616}) else $error("data cap");
  a_hdr_req_fits: assert property (req_valid |->
    hp_q + {1'b0, req_hdr} <= {1'b0, hdr_capacity}) else $error("hdr over");
  a_data_req_fits: assert property (req_valid |->
    dp_q + {1'b0, req_data} <= {1'b0, data_capacity}) else $error("data over");
  a_req_spans_block: assert property (req_valid |-> req_hdr != 10'h000)
    else $error("request with no header need");
  a_req_one_pulse: assert property (req_valid |=> !req_valid)
    else $error("request pulse too long");
  a_credit_on_done: assert property ((cpl_hdr != 10'h000) |-> rel)
    else $error("credits returned before done");
  a_free_le_held: assert property (rel |-> {1'b0, cpl_hdr} <= hp_q
    && {1'b0, cpl_data} <= dp_q) else $error("freed more than held");
  a_rx_no_stall: assert property (rx_ready)
    else $error("receive side stalled");
  c_req: cover property (req_valid && hp_q != 11'h000);
  c_rel: cover property (rel);
  c_full: cover property (req_valid ##1 hp_q == 11'd36);
endmodule
`default_nettype wire

// ---- tb/completion_credit_manager_tb.sv ----
// Self-checking bench: both ends joined by the link, APB from the bench.
// Assumes the endpoint returns the credits of its last request only.
`timescale 1ns/1ps
`default_nettype none
module completion_credit_manager_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  cfg_mrs_code = 3'h0;
  logic        cfg_rcb_128 = 1'b0;
  logic [1:0]  cfg_mps = 2'h0;
  logic        cfg_high_perf = 1'b0;
  logic        cfg_keep_digest = 1'b0;
  logic        cpl_return = 1'b0;
  logic        cpl_last = 1'b0;
  logic        overflow;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          fails = 0;
  int          n_tests = 0;
  logic [9:0]  cap_tab [8] = '{10'd77, 10'd77, 10'd154, 10'd308,
                               10'd154, 10'd154, 10'd308, 10'd616};
  always #5 clk = ~clk;
  ccm_link_if lnk (.clk(clk), .nrst(nrst));
  ccm_endpoint ccm_endpoint_inst (.lnk(lnk.endpoint),
    .cfg_mrs_code(cfg_mrs_code), .cfg_rcb_128(cfg_rcb_128),
    .cfg_mps(cfg_mps), .cfg_high_perf(cfg_high_perf),
    .cfg_keep_digest(cfg_keep_digest), .cpl_return(cpl_return),
    .cpl_last(cpl_last), .overflow(overflow));
  ccm_manager ccm_manager_inst (.lnk(lnk.manager), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ccm_link_monitor ccm_link_monitor_inst (.clk(clk), .nrst(nrst),
    .hdr_capacity(lnk.hdr_capacity), .data_capacity(lnk.data_capacity),
    .cpl_unlimited(lnk.cpl_unlimited), .req_valid(lnk.req_valid),
    .req_hdr(lnk.req_hdr), .req_data(lnk.req_data),
    .cpl_valid(lnk.cpl_valid), .cpl_hdr(lnk.cpl_hdr),
    .cpl_data(lnk.cpl_data), .cpl_done(lnk.cpl_done),
    .rx_ready(lnk.rx_ready));
  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d,
                     output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fails++;
      $display("ERROR %0t no pready from slave", $time);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
  endtask
  // f[0] use configuration fields, f[1] request returns no data
  task automatic go(input logic [2:0] m, input logic [1:0] f,
                    input logic [31:0] ad, input logic [31:0] ln);
    wr(ccm_pkg::REG_REQ_ADDR, ad);
    wr(ccm_pkg::REG_REQ_LEN, ln);
    // GO sizes the request with the mode already held in CTRL
    wr(ccm_pkg::REG_CTRL, {26'h0, f, 1'b0, m});
    wr(ccm_pkg::REG_CTRL, 32'h100 | {26'h0, f, 1'b0, m});
  endtask
  // Bit 1 depends on the next request, so only issued/blocked/too long
  task automatic st(input logic [31:0] e);
    logic [31:0] d;
    rd(ccm_pkg::REG_STATUS, d);
    chk(d & 32'hd, e);
  endtask
  task automatic pend(input logic [7:0] n, input logic [9:0] dd,
                      input logic [9:0] h);
    logic [31:0] d;
    rd(ccm_pkg::REG_PENDING, d);
    chk({4'h0, d[27:0]}, {4'h0, n, dd, h});
  endtask
  task automatic ret(input logic last);
    cpl_return <= 1'b1;
    cpl_last <= last;
    @(posedge clk);
    cpl_return <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    pend(8'h00, 10'h000, 10'h000);
    rd(ccm_pkg::REG_CAPACITY, d);
    chk(d, {12'h0, 10'd77, 10'd36});
    rd(ccm_pkg::REG_STATUS, d);
    chk({31'h0, d[4]}, 32'h1);
  endtask
  task automatic t_config();
    for (int k = 0; k < 8; k++) begin
      cfg_high_perf <= k[2];
      cfg_mps <= k[1:0];
      cfg_mrs_code <= 3'(k % 6);
      cfg_rcb_128 <= k[0];
      repeat (2) @(posedge clk);
      chk({22'h0, lnk.data_capacity}, {22'h0, cap_tab[k]});
      chk({29'h0, lnk.dev_control[14:12]}, 32'(k % 6));
      chk({31'h0, lnk.link_control[3]}, {31'h0, k[0]});
    end
    cfg_high_perf <= 1'b0;
    cfg_mps <= 2'h0;
    cfg_rcb_128 <= 1'b1;
    cfg_mrs_code <= 3'h1;
    do_reset();
  endtask
  task automatic t_align();
    go(3'h1, 2'h0, 32'h7c, 32'd8);
    st(32'h1);
    pend(8'h01, 10'd2, 10'd2);
    ret(1'b0);
    pend(8'h01, 10'd2, 10'd2);
    ret(1'b1);
    pend(8'h00, 10'd0, 10'd0);
    go(3'h1, 2'h0, 32'h20, 32'd64);
    pend(8'h01, 10'd4, 10'd2);
    ret(1'b1);
    go(3'h1, 2'h1, 32'h20, 32'd64);
    pend(8'h01, 10'd4, 10'd1);
    ret(1'b1);
    go(3'h1, 2'h0, 32'h0, 32'd129);
    st(32'h8);
    go(3'h1, 2'h1, 32'h0, 32'd256);
    st(32'h1);
    ret(1'b1);
    cfg_keep_digest <= 1'b1;
    do_reset();
    go(3'h1, 2'h0, 32'h0, 32'd32);
    pend(8'h01, 10'd3, 10'd1);
    cfg_keep_digest <= 1'b0;
  endtask
  task automatic t_fill(input int n);
    do_reset();
    repeat (n) go(3'h1, 2'h0, 32'h30, 32'd128);
    pend(n[7:0], 10'(8 * n), 10'(3 * n));
    go(3'h1, 2'h0, 32'h30, 32'd128);
    st(32'h4);
    ret(1'b1);
    go(3'h1, 2'h0, 32'h30, 32'd128);
    st(32'h1);
  endtask
  task automatic t_other();
    logic [31:0] d;
    logic        e;
    // Count cap is worked out for the good level at 128 B payload
    cfg_high_perf <= 1'b0;
    cfg_mps <= 2'h0;
    do_reset();
    repeat (ccm_pkg::NP_LIMIT_DEF) go(3'h0, 2'h0, 32'h0, 32'd4);
    go(3'h0, 2'h0, 32'h0, 32'd4);
    st(32'h4);
    rd(ccm_pkg::REG_PENDING, d);
    chk({24'h0, d[27:20]}, {24'h0, ccm_pkg::NP_LIMIT_DEF});
    for (int m = 2; m < 5; m++) begin
      do_reset();
      go(3'(m), 2'h0, 32'h7c, 32'd8);
      st(32'h1);
      if (m == 2) pend(8'h01, 10'd8, 10'd2);
      else if (m == 3) pend(8'h01, 10'd2, 10'd2);
      else pend(8'h00, 10'd0, 10'd0);
      ret(1'b1);
      pend(8'h00, 10'd0, 10'd0);
    end
    do_reset();
    go(3'h1, 2'h2, 32'h0, 32'd4);
    pend(8'h01, 10'd0, 10'd1);
    cfg_mrs_code <= 3'h6;
    go(3'h1, 2'h1, 32'h0, 32'd256);
    st(32'h8);
    apb(1'b0, 8'h18, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    apb(1'b1, ccm_pkg::REG_STATUS, 32'hf, d, e);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, overflow}, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_config();
    t_align();
    t_fill(9);
    cfg_high_perf <= 1'b1;
    cfg_mps <= ccm_pkg::MPS_1024;
    t_fill(12);
    t_other();
    give_verdict();
  end
endmodule
`default_nettype wire
